// *** pkg/pxs_pkg.sv ***
// constants for the port extended setup register pair
// assumes a config-state index/data port driven by host decode logic
// How it works
// R1 - index 04h reaches extended setup, resets 00h
// R2 - index 05h reaches floppy setup, resets 00h
// R3 - bits 1:0 pick parallel mode when ungated
// R4 - ecp+epp mode allows epp via ecr 100
// R5 - ecp modes enter spp via ecr 000
// R6 - bits 3:2 pick parallel floppy variant
// R7 - ecp modes support two drives directly
// R8 - bit 4 sets port one prescaler 13/12
// R9 - bit 5 sets port two prescaler 13/12
// R10 - midi gives 24mhz/12/16 = 125khz
// R11 - bit 6 picks epp 1.9 or 1.7
// R12 - reserved bits read zero, not writable
// R13 - floppy bit 0 open-drain or push-pull
// R14 - floppy bit 1 tri-states floppy outputs
// R15 - output bits spare the parallel floppy pins
// R16 - floppy bit 2 picks burst or per-byte dma
// R17 - force bit holds density pin high
// R18 - tri-state floats density pin, ignores force
// R19 - force bit defaults to one
package pxs_pkg;
   localparam logic [7:0] PXS_IDX_EXT = 8'h04;
   localparam logic [7:0] PXS_IDX_FLP = 8'h05;
   localparam logic [7:0] PXS_EXT_RST = 8'h00;
   localparam logic [7:0] PXS_FLP_RST = 8'h00;
   localparam logic [7:0] PXS_EXT_WMASK = 8'h7F;
   localparam logic [7:0] PXS_FLP_WMASK = 8'h1F;
   localparam logic PXS_FORCE_RST = 1'b1;
   localparam int PXS_MODE_LSB = 0;
   localparam int PXS_PPFD_LSB = 2;
   localparam int PXS_MIDI1_BIT = 4;
   localparam int PXS_MIDI2_BIT = 5;
   localparam int PXS_EPPT_BIT = 6;
   localparam int PXS_OTYPE_BIT = 0;
   localparam int PXS_OTRI_BIT = 1;
   localparam int PXS_DMA_BIT = 2;
   localparam int PXS_DENS_LSB = 3;
   localparam logic [3:0] PXS_DIV_STD = 4'hD;
   localparam logic [3:0] PXS_DIV_MIDI = 4'hC;
   localparam logic [2:0] PXS_ECR_SPP = 3'h0;
   localparam logic [2:0] PXS_ECR_EPP = 3'h4;
   localparam logic [1:0] PXS_MODE_SPP = 2'h0;
   localparam logic [1:0] PXS_MODE_EPP = 2'h1;
   localparam logic [1:0] PXS_MODE_ECP = 2'h2;
   localparam logic [1:0] PXS_MODE_BOTH = 2'h3;
   localparam logic [2:0] PXS_DRIVES_DIRECT = 3'h2;
   localparam logic [2:0] PXS_DRIVES_MAX = 3'h4;
   typedef enum logic [1:0] {PXS_OP_SPP, PXS_OP_EPP, PXS_OP_ECP} pxs_op_t;
endpackage

// *** rtl/pxs_sync2.sv ***
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ns
module pxs_sync2 (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic d_i,
   output logic q_o
);
   logic meta_r;
   // first flop only feeds the second
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         meta_r <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

// *** rtl/pxs_setup_regs.sv ***
// extended setup and floppy setup registers with derived controls
// assumes host decode gives config state, index and data strobes on sys_clk_i
`timescale 1ns/1ns
module pxs_setup_regs (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic cfg_state_i,
   input wire logic [7:0] config_select_index_i,
   input wire logic data_wr_i,
   input wire logic data_rd_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_hit_o,
   input wire logic mode_gate_i,
   input wire logic force_wr_i,
   input wire logic force_val_i,
   input wire logic ecr_wr_i,
   input wire logic [2:0] ecr_mode_i,
   input wire logic density_fn_i,
   output logic [1:0] pp_op_o,
   output logic [1:0] pp_floppy_o,
   output logic [2:0] pp_drives_o,
   output logic [3:0] uart1_div_o,
   output logic [3:0] uart2_div_o,
   output logic midi1_en_o,
   output logic midi2_en_o,
   output logic epp17_o,
   output logic floppy_ctrl_pushpull_o,
   output logic floppy_ctrl_dma_nonburst_o,
   output logic [1:0] density_select_override_o,
   output logic drive_density_out1_o,
   output logic drive_density_out1_oe_o,
   output logic force_bit_o
);
   logic [7:0] ext_r;
   logic [7:0] flp_r;
   logic force_r;
   logic ecr_spp_r;
   logic ecr_epp_r;
   logic [1:0] pp_op_r;
   logic dens_sync;
   logic [7:0] rd_nxt;
   logic hit_nxt;
   pxs_pkg::pxs_op_t op_nxt;

   // density function is a pin level from the floppy core domain
   pxs_sync2 u_dens_sync (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .d_i(density_fn_i),
      .q_o(dens_sync)
   );

   // address decode
   wire sel_ext = cfg_state_i && (config_select_index_i == pxs_pkg::PXS_IDX_EXT); // R1
   wire sel_flp = cfg_state_i && (config_select_index_i == pxs_pkg::PXS_IDX_FLP); // R2
   wire [1:0] mode_f = ext_r[pxs_pkg::PXS_MODE_LSB +: 2];
   wire ecp_mode = mode_f[1];
   wire midi1 = ext_r[pxs_pkg::PXS_MIDI1_BIT];
   wire midi2 = ext_r[pxs_pkg::PXS_MIDI2_BIT];
   wire tri_on = flp_r[pxs_pkg::PXS_OTRI_BIT];
   wire ecr_ok = ecr_wr_i && (mode_f == pxs_pkg::PXS_MODE_BOTH);
   // effective parallel operation
   always_comb begin
      op_nxt = pxs_pkg::PXS_OP_SPP;
      if (!mode_gate_i) begin
         unique case (mode_f)
            pxs_pkg::PXS_MODE_SPP: op_nxt = pxs_pkg::PXS_OP_SPP; // R3
            pxs_pkg::PXS_MODE_EPP: op_nxt = pxs_pkg::PXS_OP_EPP; // R3
            pxs_pkg::PXS_MODE_ECP: op_nxt = ecr_spp_r ? pxs_pkg::PXS_OP_SPP : pxs_pkg::PXS_OP_ECP; // R5
            // spp request wins over the epp one in the combined setting
            pxs_pkg::PXS_MODE_BOTH: op_nxt = ecr_spp_r ? pxs_pkg::PXS_OP_SPP
                                    : (ecr_epp_r ? pxs_pkg::PXS_OP_EPP : pxs_pkg::PXS_OP_ECP); // R4 R5
         endcase
      end
   end
   // read mux, reserved bits masked
   always_comb begin
      rd_nxt = 8'h00;
      hit_nxt = 1'b0;
      if (data_rd_i && sel_ext) begin
         rd_nxt = ext_r & pxs_pkg::PXS_EXT_WMASK; // R12
         hit_nxt = 1'b1;
      end else if (data_rd_i && sel_flp) begin
         rd_nxt = flp_r & pxs_pkg::PXS_FLP_WMASK; // R12
         hit_nxt = 1'b1;
      end
   end

   // register writes
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ext_r <= pxs_pkg::PXS_EXT_RST; // R1
         flp_r <= pxs_pkg::PXS_FLP_RST; // R2
         force_r <= pxs_pkg::PXS_FORCE_RST; // R19
      end else begin
         if (data_wr_i && sel_ext) ext_r <= data_i & pxs_pkg::PXS_EXT_WMASK; // R12
         if (data_wr_i && sel_flp) flp_r <= data_i & pxs_pkg::PXS_FLP_WMASK; // R12
         if (force_wr_i) force_r <= force_val_i; // R19
      end
   end

   // ecr mode tracking: 000 gives spp in both ecp settings, 100 gives epp in the combined one
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ecr_spp_r <= 1'b0;
         ecr_epp_r <= 1'b0;
      end else if (!ecp_mode) begin
         ecr_spp_r <= 1'b0;
         ecr_epp_r <= 1'b0;
      end else if (ecr_wr_i) begin
         ecr_spp_r <= (ecr_mode_i == pxs_pkg::PXS_ECR_SPP); // R5
         ecr_epp_r <= ecr_ok && (ecr_mode_i == pxs_pkg::PXS_ECR_EPP); // R4
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         data_o <= 8'h00;
         data_hit_o <= 1'b0;
         pp_op_r <= 2'h0;
         pp_floppy_o <= 2'h0;
         pp_drives_o <= pxs_pkg::PXS_DRIVES_MAX;
         uart1_div_o <= pxs_pkg::PXS_DIV_STD;
         uart2_div_o <= pxs_pkg::PXS_DIV_STD;
         midi1_en_o <= 1'b0;
         midi2_en_o <= 1'b0;
         epp17_o <= 1'b0;
         floppy_ctrl_pushpull_o <= 1'b0;
         floppy_ctrl_dma_nonburst_o <= 1'b0;
         density_select_override_o <= 2'h0;
         drive_density_out1_o <= 1'b1;
         drive_density_out1_oe_o <= 1'b0;
         force_bit_o <= pxs_pkg::PXS_FORCE_RST;
      end else begin
         data_o <= rd_nxt;
         data_hit_o <= hit_nxt;
         pp_op_r <= 2'(op_nxt);
         // parallel floppy variant takes nothing from the floppy setup bits
         pp_floppy_o <= ext_r[pxs_pkg::PXS_PPFD_LSB +: 2]; // R6 R15
         pp_drives_o <= ecp_mode ? pxs_pkg::PXS_DRIVES_DIRECT : pxs_pkg::PXS_DRIVES_MAX; // R7
         uart1_div_o <= midi1 ? pxs_pkg::PXS_DIV_MIDI : pxs_pkg::PXS_DIV_STD; // R8
         uart2_div_o <= midi2 ? pxs_pkg::PXS_DIV_MIDI : pxs_pkg::PXS_DIV_STD; // R9
         midi1_en_o <= midi1; // R10
         midi2_en_o <= midi2; // R10
         epp17_o <= ext_r[pxs_pkg::PXS_EPPT_BIT]; // R11
         floppy_ctrl_pushpull_o <= flp_r[pxs_pkg::PXS_OTYPE_BIT]; // R13
         floppy_ctrl_dma_nonburst_o <= flp_r[pxs_pkg::PXS_DMA_BIT]; // R16
         density_select_override_o <= flp_r[pxs_pkg::PXS_DENS_LSB +: 2];
         // pin level: forced high or normal function
         drive_density_out1_o <= force_r ? 1'b1 : dens_sync; // R17
         // drive only when outputs active; push-pull or open-drain low
         drive_density_out1_oe_o <= !tri_on && (flp_r[pxs_pkg::PXS_OTYPE_BIT]
                                    || !(force_r || dens_sync)); // R14 R18 R13
         force_bit_o <= force_r;
      end
   end
   assign pp_op_o = pp_op_r;

   // checks: read path and reserved bits
   chk_ext_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
      data_hit_o |-> !(data_o[7] && $past(sel_ext)))
      else $error("reserved ext bit read one");
   chk_flp_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R12
      (data_hit_o && $past(sel_flp)) |-> data_o[7:5] == 3'h0)
      else $error("reserved floppy bits read one");
   chk_read_ext_value: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R1
      (data_rd_i && sel_ext) |=> data_hit_o && data_o == $past(ext_r))
      else $error("ext read value wrong");
   chk_read_miss_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R1
      (data_rd_i && !sel_ext && !sel_flp) |=> !data_hit_o && data_o == 8'h00)
      else $error("refused read answered");

   // checks: write decode
   chk_ext_write_index: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R1
      (data_wr_i && !sel_ext) |=> ext_r == $past(ext_r))
      else $error("ext written off index");
   chk_flp_write_index: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R2
      (data_wr_i && sel_flp) |=> flp_r == ($past(data_i) & 8'h1F))
      else $error("floppy write lost");

   // checks: parallel mode selection and ecr overrides
   chk_gate_forces_spp: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R3
      mode_gate_i |=> pp_op_o == 2'(pxs_pkg::PXS_OP_SPP))
      else $error("gated mode not spp");
   chk_mode_epp_code: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R3
      (!mode_gate_i && mode_f == 2'h1) |=> pp_op_o == 2'(pxs_pkg::PXS_OP_EPP))
      else $error("mode code 01 not epp");
   chk_ecr_epp_entry: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R4
      (ecr_ok && ecr_mode_i == 3'h4) ##1 (!mode_gate_i && mode_f == 2'h3) |=> pp_op_o == 2'(pxs_pkg::PXS_OP_EPP))
      else $error("ecr 100 gave no epp");
   chk_ecr_spp_entry: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R5
      (ecr_wr_i && ecp_mode && ecr_mode_i == 3'h0) ##1 (!mode_gate_i && ecp_mode) |=> pp_op_o == 2'(pxs_pkg::PXS_OP_SPP))
      else $error("ecr 000 gave no spp");
   chk_ecp_drives: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R7
      ecp_mode |=> pp_drives_o == 3'h2)
      else $error("ecp drive count wrong");
   chk_non_ecp_drives: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R7
      !ecp_mode |=> pp_drives_o == 3'h4)
      else $error("non-ecp drive count wrong");
   chk_ppfd_sel: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R6
      pp_floppy_o == $past(ext_r[3:2]))
      else $error("floppy variant not tracked");
   chk_ppfd_spared: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R15
      (data_wr_i && sel_flp) |=> ##1 $stable(pp_floppy_o))
      else $error("floppy setup moved parallel floppy");

   // checks: serial prescalers and epp type
   chk_midi1_div: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R8
      midi1 |=> uart1_div_o == 4'hC)
      else $error("port one divisor wrong");
   chk_midi2_div: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R9
      !midi2 |=> uart2_div_o == 4'hD)
      else $error("port two divisor wrong");
   chk_midi_enables: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R10
      midi1_en_o == $past(midi1) && midi2_en_o == $past(midi2))
      else $error("midi enable not tracked");
   chk_epp_type: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R11
      epp17_o == $past(ext_r[6]))
      else $error("epp type not tracked");

   // checks: floppy outputs and density pin
   chk_pushpull_bit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R13
      floppy_ctrl_pushpull_o == $past(flp_r[0]))
      else $error("output type not tracked");
   chk_open_drain_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R13
      (!flp_r[0] && force_r) |=> !drive_density_out1_oe_o)
      else $error("open drain drove a high level");
   chk_active_drives_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R14
      (!tri_on && !force_r && !dens_sync) |=> drive_density_out1_oe_o)
      else $error("active output not driving low");
   chk_tri_floats_pin: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R18
      tri_on |=> !drive_density_out1_oe_o)
      else $error("density pin driven in tri-state");
   chk_dma_mode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R16
      floppy_ctrl_dma_nonburst_o == $past(flp_r[2]))
      else $error("dma mode not tracked");
   chk_force_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R17
      force_r |=> drive_density_out1_o)
      else $error("forced density pin low");
   chk_force_follows: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R17
      !force_r |=> drive_density_out1_o == $past(dens_sync))
      else $error("density pin not following function");
   chk_force_bit_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // R19
      force_wr_i |=> ##1 force_bit_o == $past(force_val_i, 2))
      else $error("force bit write lost");

   // main scenarios
   cov_midi_both: cover property (@(posedge sys_clk_i) midi1_en_o && midi2_en_o);
   cov_epp_via_ecr: cover property (@(posedge sys_clk_i) ecr_epp_r && mode_f == 2'h3);
   cov_spp_via_ecr: cover property (@(posedge sys_clk_i) ecr_spp_r && mode_f == 2'h3);
   cov_tri_state: cover property (@(posedge sys_clk_i) tri_on ##1 !drive_density_out1_oe_o);
   cov_open_drain_low: cover property (@(posedge sys_clk_i) !floppy_ctrl_pushpull_o && drive_density_out1_oe_o);
endmodule

// *** bench/tb_port_extended_setup_regs.sv ***
// self-checking bench for the extended setup and floppy setup register pair
// assumes the design checks its own timing with assertions; the bench drives every input itself
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_port_extended_setup_regs;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, cfg_state_i = 1'b0, data_wr_i = 1'b0, data_rd_i = 1'b0;
   logic mode_gate_i = 1'b0, force_wr_i = 1'b0, force_val_i = 1'b0, ecr_wr_i = 1'b0, density_fn_i = 1'b0;
   logic [7:0] config_select_index_i = 8'h00, data_i = 8'h00, data_o, v, e;
   logic [2:0] ecr_mode_i = 3'h0, pp_drives_o;
   logic [1:0] pp_op_o, pp_floppy_o, density_select_override_o;
   logic [3:0] uart1_div_o, uart2_div_o;
   logic data_hit_o, midi1_en_o, midi2_en_o, epp17_o, floppy_ctrl_pushpull_o, floppy_ctrl_dma_nonburst_o;
   logic drive_density_out1_o, drive_density_out1_oe_o, force_bit_o;
   logic [7:0] exp_q[$];
   int fail_count = 0, comparisons = 0, m;
   // free-running system clock, 40 ns period
   always #20 sys_clk_i = ~sys_clk_i;
   pxs_setup_regs dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cfg_state_i(cfg_state_i),
      .config_select_index_i(config_select_index_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
      .data_i(data_i), .data_o(data_o), .data_hit_o(data_hit_o), .mode_gate_i(mode_gate_i),
      .force_wr_i(force_wr_i), .force_val_i(force_val_i), .ecr_wr_i(ecr_wr_i), .ecr_mode_i(ecr_mode_i),
      .density_fn_i(density_fn_i), .pp_op_o(pp_op_o), .pp_floppy_o(pp_floppy_o), .pp_drives_o(pp_drives_o),
      .uart1_div_o(uart1_div_o), .uart2_div_o(uart2_div_o), .midi1_en_o(midi1_en_o), .midi2_en_o(midi2_en_o),
      .epp17_o(epp17_o), .floppy_ctrl_pushpull_o(floppy_ctrl_pushpull_o),
      .floppy_ctrl_dma_nonburst_o(floppy_ctrl_dma_nonburst_o),
      .density_select_override_o(density_select_override_o), .drive_density_out1_o(drive_density_out1_o),
      .drive_density_out1_oe_o(drive_density_out1_oe_o), .force_bit_o(force_bit_o));
   // one-cycle write strobe at the given index
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge sys_clk_i);
      config_select_index_i <= i;
      data_i <= d;
      data_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      data_wr_i <= 1'b0;
   endtask
   // read strobe; a hit notes its value, a miss is checked at once
   task automatic rd(input logic [7:0] i, input logic [7:0] d, input logic hit);
      @(posedge sys_clk_i);
      config_select_index_i <= i;
      data_rd_i <= 1'b1;
      if (hit) exp_q.push_back(d);
      @(posedge sys_clk_i);
      data_rd_i <= 1'b0;
      if (!hit) begin
         @(negedge sys_clk_i);
         `CHK(data_hit_o, 1'b0)
         `CHK(data_o, 8'h00)
      end
   endtask
   // strobes for the density force bit and the ecr mode field
   task automatic frc(input logic f);
      @(posedge sys_clk_i);
      force_val_i <= f;
      force_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      force_wr_i <= 1'b0;
   endtask
   task automatic ecr(input logic [2:0] md);
      @(posedge sys_clk_i);
      ecr_mode_i <= md;
      ecr_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      ecr_wr_i <= 1'b0;
   endtask
   // lets registered and synchronised outputs land
   task automatic settle();
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask
   task automatic end_of_test();
      if (exp_q.size() != 0) fail_count++;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // read monitor: oldest note against each hit
   always @(negedge sys_clk_i) begin
      if (data_hit_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("[ERR] %0t unexpected read data", $time);
         end else begin
            e = exp_q.pop_front();
            `CHK(data_o, e)
         end
      end
   end
   // hang guard
   initial begin
      #100000;
      fail_count++;
      end_of_test();
   end
   // main sequence
   initial begin
      void'($urandom(56338));
      repeat (12) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      cfg_state_i <= 1'b1;
      rd(8'h04, 8'h00, 1'b1);
      rd(8'h05, 8'h00, 1'b1);
      settle();
      `CHK(uart1_div_o, 4'hD)
      `CHK(pp_drives_o, 3'h4)
      `CHK(force_bit_o, 1'b1)
      // every parallel mode and floppy variant code, midi and epp bits both ways
      for (m = 0; m < 4; m++) begin
         v = 8'($urandom);
         v[6:0] = {m[1], ~m[0], m[0], m[1:0], m[1:0]};
         wr(8'h04, v);
         rd(8'h04, v & 8'h7F, 1'b1);
         settle();
         `CHK(pp_op_o, (m == 0) ? 2'h0 : ((m == 1) ? 2'h1 : 2'h2))
         `CHK(pp_floppy_o, v[3:2])
         `CHK(pp_drives_o, m[1] ? 3'h2 : 3'h4)
         `CHK(uart1_div_o, v[4] ? 4'hC : 4'hD)
         `CHK(uart2_div_o, v[5] ? 4'hC : 4'hD)
         `CHK(midi2_en_o, v[5])
         `CHK(midi1_en_o, v[4])
         `CHK(epp17_o, v[6])
      end
      @(posedge sys_clk_i);
      mode_gate_i <= 1'b1;
      settle();
      `CHK(pp_op_o, 2'h0)
      @(posedge sys_clk_i);
      mode_gate_i <= 1'b0;
      ecr(3'h4);
      settle();
      `CHK(pp_op_o, 2'h1)
      // combined then ecp-only setting: ecr 000 falls back to spp, another code to ecp
      ecr(3'h0);
      settle();
      `CHK(pp_op_o, 2'h0)
      ecr(3'h1);
      settle();
      `CHK(pp_op_o, 2'h2)
      wr(8'h04, 8'h02);
      settle();
      `CHK(pp_op_o, 2'h2)
      ecr(3'h0);
      settle();
      `CHK(pp_op_o, 2'h0)
      // refused accesses: outside config state and unmapped index
      @(posedge sys_clk_i);
      cfg_state_i <= 1'b0;
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h00, 1'b0);
      @(posedge sys_clk_i);
      cfg_state_i <= 1'b1;
      rd(8'h04, 8'h02, 1'b1);
      rd(8'h06, 8'h00, 1'b0);
      // floppy setup fields with outputs tri-stated
      v = 8'($urandom) | 8'h02;
      wr(8'h05, v);
      rd(8'h05, v & 8'h1F, 1'b1);
      frc(1'b0);
      settle();
      `CHK(floppy_ctrl_pushpull_o, v[0])
      `CHK(floppy_ctrl_dma_nonburst_o, v[2])
      `CHK(density_select_override_o, v[4:3])
      `CHK(pp_floppy_o, 2'h0)
      `CHK(force_bit_o, 1'b0)
      `CHK(drive_density_out1_oe_o, 1'b0)
      // outputs active, push-pull: density pin follows function, then forced high
      wr(8'h05, 8'h01);
      density_fn_i <= 1'b1;
      settle();
      `CHK(drive_density_out1_o, 1'b1)
      `CHK(drive_density_out1_oe_o, 1'b1)
      @(posedge sys_clk_i);
      density_fn_i <= 1'b0;
      settle();
      `CHK(drive_density_out1_o, 1'b0)
      frc(1'b1);
      settle();
      `CHK(drive_density_out1_o, 1'b1)
      wr(8'h05, 8'h00);
      settle();
      `CHK(drive_density_out1_oe_o, 1'b0)
      // open drain still pulls a low level
      frc(1'b0);
      settle();
      `CHK(drive_density_out1_oe_o, 1'b1)
      end_of_test();
   end
endmodule
